// *** core/nest_irq_pkg.sv ***
// Constants and types for the nested interrupt priority unit
package nest_irq_pkg;

  localparam int NUM_VEC = 14;

  // ****************************************
  // Register map, one aligned word each
  // ****************************************
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_VP0   = 8'h04;
  localparam logic [7:0] OFS_VP3   = 8'h10;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int         BIT_HI    = 5;
  localparam int         BIT_LO    = 3;
  localparam logic [7:0] FLAGS_RST = 8'hEA;
  localparam logic [7:0] FLAGS_TOP = 8'hC0;
  localparam logic [7:0] VP_RST    = 8'hFF;
  localparam logic [1:0] CODE_L0   = 2'b10;
  localparam logic [1:0] CODE_L3   = 2'b11;

  // ****************************************
  // Vector addresses and halt wake masks
  // ****************************************
  localparam logic [15:0] VEC_RESET   = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP    = 16'hFFFC;
  localparam logic [15:0] VEC_BASE    = 16'hFFFA;
  localparam logic [13:0] WAKE_HALT   = 14'h0070;
  localparam logic [13:0] WAKE_AWU    = 14'h0071;
  localparam logic [13:0] WAKE_ACTIVE = 14'h2170;

  typedef enum logic [2:0] {
    OP_NONE    = 3'b000,
    OP_ENABLE  = 3'b001,
    OP_DISABLE = 3'b010,
    OP_WAIT    = 3'b011,
    OP_HALT    = 3'b100,
    OP_POP     = 3'b101,
    OP_RETURN  = 3'b110,
    OP_TRAP    = 3'b111
  } instr_op_t;

  typedef enum logic [1:0] {
    PM_RUN    = 2'b00,
    PM_HALT   = 2'b01,
    PM_ACTIVE = 2'b10,
    PM_AWU    = 2'b11
  } pmode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        push;
    logic        nmi;
    logic [3:0]  num;
    logic [15:0] addr;
    logic [7:0]  pushed_flags;
  } service_t;

endpackage

// *** core/nest_irq_unit.sv ***
// Nested interrupt priority unit: flag level bits, vector priorities, arbitration
`timescale 1ns/10ps
`default_nettype none
module nest_irq_unit
  import nest_irq_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire nest_irq_pkg::apb_req_t  apb_req,
  output      nest_irq_pkg::apb_rsp_t  apb_rsp,
  input  wire logic [13:0]             irq_req,
  input  wire logic [13:0]             irq_en,
  input  wire logic                    instr_boundary,
  input  wire nest_irq_pkg::instr_op_t instr_op,
  input  wire logic [7:0]              stacked_flags,
  input  wire nest_irq_pkg::pmode_t    pmode,
  output      logic [7:0]              cpu_flags,
  output      nest_irq_pkg::service_t  svc,
  output      logic                    branch_if_masked,
  output      logic                    branch_if_unmasked,
  output      logic                    wake
);
  import nest_irq_pkg::*;

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_ff;
  logic rstn_s;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'b0;
      rstn_s      <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rstn_s      <= rst_meta_ff;
    end
  end

  function automatic logic [1:0] lvl_of(input logic [1:0] code);
    logic [1:0] l;
    case (code)
      2'b10:   l = 2'd0;
      2'b01:   l = 2'd1;
      2'b00:   l = 2'd2;
      default: l = 2'd3;
    endcase
    return l;
  endfunction

  function automatic logic [7:0] set_code(input logic [7:0] f, input logic [1:0] c);
    logic [7:0] r;
    r         = f;
    r[BIT_HI] = c[1];
    r[BIT_LO] = c[0];
    return r;
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [7:0]  flags_ff;
  logic [7:0]  nxt_flags;
  logic [31:0] vp_ff;
  logic [31:0] nxt_vp;
  logic        rst_pend_ff;
  service_t    svc_ff;
  service_t    nxt_svc;
  logic        masked_ff;
  logic        unmasked_ff;
  logic        wake_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;

  // ****************************************
  // APB decode
  // ****************************************
  wire        setup     = apb_req.psel & ~apb_req.penable;
  wire        access    = apb_req.psel & apb_req.penable & pready_ff;
  wire        hit_flags = apb_req.paddr == OFS_FLAGS;
  wire        hit_vp    = (apb_req.paddr >= OFS_VP0) && (apb_req.paddr <= OFS_VP3)
                          && (apb_req.paddr[1:0] == 2'b00);
  wire [1:0]  vidx      = 2'(apb_req.paddr[4:2] - 3'd1);
  wire        mapped    = hit_flags | hit_vp;
  wire        wr_flags  = access & apb_req.pwrite & hit_flags;
  wire        wr_vp     = access & apb_req.pwrite & hit_vp;
  // stored pairs read back as held
  wire [31:0] rdata     = hit_flags ? {24'h0000_00, flags_ff}
                        : hit_vp ? {24'h0000_00, vp_ff[8*vidx +: 8]} : 32'h0000_0000;

  // level-0 writes leave the pair alone
  always_comb begin
    nxt_vp = vp_ff;
    for (int p = 0; p < 16; p++) begin
      if (wr_vp && (vidx == 2'(p / 4)) && p < 14
          && apb_req.pwdata[2*(p%4) +: 2] != CODE_L0) begin
        nxt_vp[2*p +: 2] = apb_req.pwdata[2*(p%4) +: 2];
      end
    end
  end

  // ****************************************
  // Instruction effect on the level bits
  // ****************************************
  logic [7:0] after_op;

  always_comb begin
    after_op = flags_ff;
    if (instr_boundary) begin
      case (instr_op)
        OP_ENABLE, OP_WAIT, OP_HALT: after_op = set_code(flags_ff, CODE_L0);
        OP_DISABLE:                  after_op = set_code(flags_ff, CODE_L3);
        OP_POP, OP_RETURN:           after_op = stacked_flags | FLAGS_TOP;
        default:                     after_op = flags_ff;
      endcase
    end
  end

  wire [1:0]  op_lvl = lvl_of({after_op[BIT_HI], after_op[BIT_LO]});
  wire [13:0] wake_ok = (pmode == PM_HALT)   ? WAKE_HALT
                      : (pmode == PM_AWU)    ? WAKE_AWU
                      : (pmode == PM_ACTIVE) ? WAKE_ACTIVE : 14'h3FFF;

  // ****************************************
  // Arbitration
  // ****************************************
  logic       best_found;
  logic [3:0] best_num;
  logic [1:0] best_lvl;
  logic [1:0] best_code;

  always_comb begin
    logic [1:0] c;
    c          = 2'b00;
    best_found = 1'b0;
    best_num   = 4'h0;
    best_lvl   = 2'd0;
    best_code  = CODE_L3;
    for (int v = 0; v < NUM_VEC; v++) begin
      c = vp_ff[2*v +: 2];
      if (irq_req[v] && irq_en[v] && wake_ok[v] && lvl_of(c) > op_lvl
          && (!best_found || lvl_of(c) > best_lvl)) begin
        best_found = 1'b1;
        best_num   = 4'(v);
        best_lvl   = lvl_of(c);
        best_code  = c;
      end
    end
  end

  wire take_trap = instr_boundary && instr_op == OP_TRAP && !rst_pend_ff;
  wire take_irq  = instr_boundary && !take_trap && best_found && !rst_pend_ff;

  // ****************************************
  // Next flags and service record
  // ****************************************
  always_comb begin
    nxt_flags = flags_ff;
    nxt_svc   = '0;
    if (rst_pend_ff) begin
      nxt_flags     = set_code(flags_ff, CODE_L3);
      nxt_svc.valid = 1'b1;
      nxt_svc.nmi   = 1'b1;
      nxt_svc.addr  = VEC_RESET;
    end else if (take_trap) begin
      nxt_flags             = set_code(after_op, CODE_L3);
      nxt_svc.valid         = 1'b1;
      nxt_svc.push          = 1'b1;
      nxt_svc.nmi           = 1'b1;
      nxt_svc.addr          = VEC_TRAP;
      nxt_svc.pushed_flags  = after_op;
    end else if (take_irq) begin
      // stack old flags, enter at vector level
      nxt_flags             = set_code(after_op, best_code);
      nxt_svc.valid         = 1'b1;
      nxt_svc.push          = 1'b1;
      nxt_svc.num           = best_num;
      nxt_svc.addr          = 16'(VEC_BASE - {11'h000, best_num, 1'b0});
      nxt_svc.pushed_flags  = after_op;
    end else if (instr_boundary) begin
      nxt_flags = after_op;
    end else if (wr_flags) begin
      // Software write loses to a boundary update
      nxt_flags = apb_req.pwdata[7:0] | FLAGS_TOP;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // reset values
  always_ff @(posedge clk or negedge rstn_s) begin
    if (!rstn_s) begin
      flags_ff    <= FLAGS_RST;
      vp_ff       <= {4{VP_RST}};
      rst_pend_ff <= 1'b1;
      svc_ff      <= '0;
    end else begin
      flags_ff    <= nxt_flags;
      vp_ff       <= nxt_vp;
      rst_pend_ff <= 1'b0;
      svc_ff      <= nxt_svc;
    end
  end

  // branch conditions follow the level code
  always_ff @(posedge clk or negedge rstn_s) begin
    if (!rstn_s) begin
      masked_ff   <= 1'b1;
      unmasked_ff <= 1'b0;
      wake_ff     <= 1'b0;
    end else begin
      masked_ff   <= {nxt_flags[BIT_HI], nxt_flags[BIT_LO]} == CODE_L3;
      unmasked_ff <= {nxt_flags[BIT_HI], nxt_flags[BIT_LO]} != CODE_L3;
      wake_ff     <= (pmode != PM_RUN) && best_found;
    end
  end

  // Answer in the access phase, no wait states
  always_ff @(posedge clk or negedge rstn_s) begin
    if (!rstn_s) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= setup ? rdata : prdata_ff;
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
    end
  end

  assign apb_rsp.prdata      = prdata_ff;
  assign apb_rsp.pready      = pready_ff;
  assign apb_rsp.pslverr     = pslverr_ff;
  assign cpu_flags           = flags_ff;
  assign svc                 = svc_ff;
  assign branch_if_masked    = masked_ff;
  assign branch_if_unmasked  = unmasked_ff;
  assign wake                = wake_ff;

  // ****************************************
  // Checks
  // ****************************************
  wire [1:0] cur_code = {flags_ff[BIT_HI], flags_ff[BIT_LO]};

  a_reset_flags_value: assert property (@(posedge clk)
    $rose(rstn_s) |-> flags_ff == FLAGS_RST && vp_ff == 32'hFFFF_FFFF)
    else $error("flags or priorities wrong after reset");

  a_entry_level_load: assert property (@(posedge clk) disable iff (!rstn_s)
    take_irq |=> cur_code == $past(best_code) && svc_ff.num == $past(best_num))
    else $error("entry level not taken from vector pair");

  a_trap_sets_three: assert property (@(posedge clk) disable iff (!rstn_s)
    take_trap |=> cur_code == CODE_L3 && svc_ff.addr == VEC_TRAP && svc_ff.push)
    else $error("trap entry wrong");

  a_enable_loads_zero: assert property (@(posedge clk) disable iff (!rstn_s)
    instr_boundary && instr_op == OP_ENABLE && !best_found && !rst_pend_ff
    |=> cur_code == CODE_L0)
    else $error("enable did not load level 0");

  a_disable_loads_three: assert property (@(posedge clk) disable iff (!rstn_s)
    instr_boundary && instr_op == OP_DISABLE && !rst_pend_ff |=> cur_code == CODE_L3)
    else $error("disable did not load level 3");

  a_level0_write_kept: assert property (@(posedge clk) disable iff (!rstn_s)
    wr_vp && vidx == 2'd0 && apb_req.pwdata[1:0] == CODE_L0
    |=> vp_ff[1:0] == $past(vp_ff[1:0]))
    else $error("level 0 pair write was stored");

  a_top_nibble_ones: assert property (@(posedge clk) disable iff (!rstn_s)
    vp_ff[31:28] == 4'hF)
    else $error("read-only nibble changed");

  a_masked_branch_match: assert property (@(posedge clk) disable iff (!rstn_s)
    ##1 masked_ff == (cur_code == CODE_L3) && branch_if_unmasked == !masked_ff)
    else $error("branch condition disagrees with level");

  a_halt_no_auto_wake: assert property (@(posedge clk) disable iff (!rstn_s)
    take_irq && pmode == PM_HALT |=> svc_ff.num != 4'h0 && svc_ff.num != 4'h8)
    else $error("vector woke plain halt illegally");

  a_level_gate_entry: assert property (@(posedge clk) disable iff (!rstn_s)
    take_irq |-> lvl_of(best_code) > op_lvl && irq_en[best_num])
    else $error("entry at or below current level");

  a_unmasked_branch_inv: assert property (@(posedge clk) disable iff (!rstn_s)
    branch_if_unmasked == (cur_code != CODE_L3))
    else $error("unmasked branch disagrees with level");

  a_reset_entry_vector: assert property (@(posedge clk) disable iff (!rstn_s)
    rst_pend_ff |=> svc_ff.valid && svc_ff.nmi && !svc_ff.push && svc_ff.addr == VEC_RESET
                    && cur_code == CODE_L3)
    else $error("reset entry wrong");

  a_trap_in_level3: assert property (@(posedge clk) disable iff (!rstn_s)
    instr_boundary && instr_op == OP_TRAP && !rst_pend_ff && cur_code == CODE_L3
    |=> svc_ff.valid && svc_ff.nmi && svc_ff.addr == VEC_TRAP)
    else $error("trap refused at level 3");

  a_entry_vector_addr: assert property (@(posedge clk) disable iff (!rstn_s)
    take_irq |=> svc_ff.num <= 4'd13 && svc_ff.addr == VEC_BASE - {11'h000, svc_ff.num, 1'b0})
    else $error("vector address does not match number");

  a_entry_stacks_flags: assert property (@(posedge clk) disable iff (!rstn_s)
    take_irq |=> svc_ff.push && !svc_ff.nmi && svc_ff.pushed_flags == $past(after_op))
    else $error("entry did not stack the flags");

  a_pop_restores_byte: assert property (@(posedge clk) disable iff (!rstn_s)
    instr_boundary && (instr_op == OP_POP || instr_op == OP_RETURN) && !best_found && !rst_pend_ff
    |=> flags_ff == ($past(stacked_flags) | FLAGS_TOP))
    else $error("stacked byte not restored");

  a_wait_loads_zero: assert property (@(posedge clk) disable iff (!rstn_s)
    instr_boundary && (instr_op == OP_WAIT || instr_op == OP_HALT) && !best_found && !rst_pend_ff
    |=> cur_code == CODE_L0)
    else $error("wait or halt did not load level 0");

  a_tie_lower_wins: assert property (@(posedge clk) disable iff (!rstn_s)
    take_irq && irq_req[0] && irq_en[0] && wake_ok[0] && lvl_of(vp_ff[1:0]) > op_lvl
    |-> best_num == 4'h0 || best_lvl > lvl_of(vp_ff[1:0]))
    else $error("vector 0 lost a tie or a higher level");

  a_timer_active_only: assert property (@(posedge clk) disable iff (!rstn_s)
    take_irq && (best_num == 4'd8 || best_num == 4'd13) |-> pmode == PM_ACTIVE || pmode == PM_RUN)
    else $error("timer vector taken in wrong halt mode");

  a_vec12_pair_slot: assert property (@(posedge clk) disable iff (!rstn_s)
    wr_vp && vidx == 2'd3 && apb_req.pwdata[1:0] != CODE_L0
    |=> vp_ff[25:24] == $past(apb_req.pwdata[1:0]))
    else $error("vector 12 pair not in low bits of fourth register");

  a_entry_not_level0: assert property (@(posedge clk) disable iff (!rstn_s)
    take_irq |=> cur_code != CODE_L0)
    else $error("entry loaded level 0 code");

  a_reg3_nibble_reads: assert property (@(posedge clk) disable iff (!rstn_s)
    setup && apb_req.paddr == OFS_VP3 |=> apb_rsp.prdata[7:4] == 4'hF)
    else $error("fourth register top nibble not read as ones");

  a_pready_single_pulse: assert property (@(posedge clk) disable iff (!rstn_s)
    apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready stood longer than one cycle");

  a_run_no_wake: assert property (@(posedge clk) disable iff (!rstn_s)
    pmode == PM_RUN |=> !wake)
    else $error("wake raised while running");

endmodule
`default_nettype wire

// *** dv/periph_req_model.sv ***
// Peripheral request latches standing on the far side of the interrupt unit
`timescale 1ns/10ps
`default_nettype none
module periph_req_model (
  input  wire logic                   clk,
  input  wire logic [13:0]            set_req,
  input  wire logic                   clr_all,
  input  wire nest_irq_pkg::service_t svc,
  output      logic [13:0]            irq_req
);
  import nest_irq_pkg::*;

  initial irq_req = '0;

  always @(posedge clk) begin
    if (clr_all) begin
      irq_req <= '0;
    end else if (svc.valid && !svc.nmi) begin
      irq_req <= (irq_req | set_req) & ~(14'h0001 << svc.num);
    end else begin
      irq_req <= irq_req | set_req;
    end
  end
endmodule
`default_nettype wire

// *** dv/nested_interrupt_priority_unit_tb_top.sv ***
// Self-checking bench for the nested interrupt priority unit
`timescale 1ns/10ps
`default_nettype none
module nested_interrupt_priority_unit_tb_top;
  import nest_irq_pkg::*;
  logic        clk, resetn, instr_boundary, clr_all, err, wk;
  logic        branch_if_masked, branch_if_unmasked, wake;
  apb_req_t    req;
  apb_rsp_t    rsp;
  instr_op_t   op;
  pmode_t      pmode;
  service_t    svc;
  logic [13:0] irq_req, irq_en, set_req;
  logic [7:0]  stacked_flags, cpu_flags, vp [4];
  logic [31:0] rs, rd, r;
  int          err_count, compares, cyc, best, bl, pl;

  nest_irq_unit dut (.clk(clk), .resetn(resetn), .apb_req(req), .apb_rsp(rsp),
    .irq_req(irq_req), .irq_en(irq_en), .instr_boundary(instr_boundary),
    .instr_op(op), .stacked_flags(stacked_flags), .pmode(pmode),
    .cpu_flags(cpu_flags), .svc(svc), .branch_if_masked(branch_if_masked),
    .branch_if_unmasked(branch_if_unmasked), .wake(wake));
  periph_req_model peer (.clk(clk), .set_req(set_req), .clr_all(clr_all),
    .svc(svc), .irq_req(irq_req));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic int lvl(logic [1:0] c);
    return (c == 2'b10) ? 0 : (c == 2'b01) ? 1 : (c == 2'b00) ? 2 : 3;
  endfunction

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic wrap_up();
    if (err_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Holds the request until the edge that samples pready high
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic vp_wr(int k, logic [7:0] d);
    for (int p = 0; p < 4; p++) begin
      if (d[2*p+:2] != 2'b10) vp[k][2*p+:2] = d[2*p+:2];
    end
    if (k == 3) vp[3][7:4] = 4'hF;
    apb(1'b1, 8'(4 + 4 * k), {24'h0000_00, d});
  endtask

  task automatic bnd(instr_op_t o, logic [7:0] sf);
    @(posedge clk);
    instr_boundary <= 1'b1;
    op <= o;
    stacked_flags <= sf;
    @(posedge clk);
    instr_boundary <= 1'b0;
    #1;
  endtask

  task automatic pulse_clr();
    @(posedge clk);
    clr_all <= 1'b1;
    @(posedge clk);
    clr_all <= 1'b0;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rs = 32'd77;
    req = '0;
    {instr_boundary, clr_all, resetn} = '0;
    op = OP_NONE;
    pmode = PM_RUN;
    {irq_en, set_req, stacked_flags} = '0;
    for (int k = 0; k < 4; k++) vp[k] = 8'hFF;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 20 && svc.valid !== 1'b1; i++) @(negedge clk);
    chk("rst_nmi", 1, svc.nmi);
    chk("rst_vec", 16'hFFFE, svc.addr);
    chk("rst_flags", 8'hEA, cpu_flags);
    chk("rst_masked", 1, branch_if_masked);
    repeat (4) @(posedge clk);
    apb(1'b0, 8'h00, 0);
    chk("flags_rd", 8'hEA, rd);
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, 8'(4 + 4 * k), 0);
      chk("vp_rst", 8'hFF, rd);
    end
    apb(1'b0, 8'h14, 0);
    chk("unmapped_err", 1, err);
    vp_wr(0, 8'hCF);
    vp_wr(0, 8'h64);
    apb(1'b0, 8'h04, 0);
    chk("vp0_keep", 8'h44, rd);
    vp_wr(3, 8'h00);
    apb(1'b0, 8'h10, 0);
    chk("vp3_ro", 8'hF0, rd);
    apb(1'b1, 8'h00, 32'h0000_0015);
    apb(1'b0, 8'h00, 0);
    chk("flags_wr", 8'hD5, rd);
    bnd(OP_ENABLE, 8'h00);
    chk("en_code", 2'b10, {cpu_flags[5], cpu_flags[3]});
    chk("unmasked", 1, branch_if_unmasked);
    for (int j = 0; j < 2; j++) begin
      bnd(OP_DISABLE, 8'h00);
      chk("dis_code", 2'b11, {cpu_flags[5], cpu_flags[3]});
      bnd(instr_op_t'(j ? OP_HALT : OP_WAIT), 8'h00);
      chk("wait_code", 2'b10, {cpu_flags[5], cpu_flags[3]});
      r = xs();
      bnd(instr_op_t'(j ? OP_RETURN : OP_POP), r[7:0]);
      chk("pop_flags", r[7:0] | 8'hC0, cpu_flags);
    end
    bnd(OP_DISABLE, 8'h00);
    bnd(OP_TRAP, 8'h00);
    chk("trap_nmi", 1, svc.valid & svc.nmi);
    chk("trap_vec", 16'hFFFC, svc.addr);
    chk("trap_code", 2'b11, {cpu_flags[5], cpu_flags[3]});
    for (int i = 0; i < 24; i++) begin
      r = xs();
      vp_wr(i % 4, r[7:0]);
      irq_en <= r[21:8];
      r = xs();
      set_req <= r[13:0];
      @(posedge clk);
      set_req <= '0;
      @(posedge clk);
      bnd(OP_ENABLE, 8'h00);
      best = -1;
      bl = 0;
      for (int v = 0; v < 14; v++) begin
        pl = lvl(vp[v / 4][2 * (v % 4)+:2]);
        if (irq_req[v] && irq_en[v] && pl > bl) begin
          best = v;
          bl = pl;
        end
      end
      chk("svc_valid", best >= 0, svc.valid);
      if (best >= 0) begin
        chk("svc_num", best, svc.num);
        chk("svc_vec", 16'hFFFA - 16'(2 * best), svc.addr);
        chk("svc_code", vp[best / 4][2 * (best % 4)+:2], {cpu_flags[5], cpu_flags[3]});
        chk("svc_push", 3'b110, {svc.push, svc.pushed_flags[5], svc.pushed_flags[3]});
      end
    end
    pulse_clr();
    irq_en <= '1;
    bnd(OP_ENABLE, 8'h00);
    @(posedge clk);
    for (int m = 1; m < 4; m++) begin
      for (int v = 0; v < 14; v++) begin
        pmode <= pmode_t'(m);
        set_req <= 14'h0001 << v;
        @(posedge clk);
        set_req <= '0;
        repeat (2) @(posedge clk);
        #1;
        wk = (v >= 4 && v <= 6) || (m == 3 && v == 0) || (m == 2 && (v == 8 || v == 13));
        chk("wake", wk, wake);
        bnd(OP_ENABLE, 8'h00);
        chk("halt_svc", wk, svc.valid);
        if (wk) chk("halt_num", v, svc.num);
        bnd(OP_ENABLE, 8'h00);
        pulse_clr();
      end
    end
    pmode <= PM_RUN;
    wrap_up();
  end
endmodule
`default_nettype wire
